//--- verilog/wdhc_defs.vh
// Purpose: constants for the watchdog, halt and reset control block
// Assumes: 10 MHz system clock, 8-bit register port
// Notes:   definitions only
`ifndef WDHC_DEFS_VH
`define WDHC_DEFS_VH

// ****************************************
// register map
// ****************************************
`define WDHC_ADDR_W         4
`define WDHC_OFS_SELECT     4'h0
`define WDHC_OFS_STATUS     4'h1
`define WDHC_SEL_RESET      8'h07
`define WDHC_SEL_PS_MSB     2
`define WDHC_SEL_PS_LSB     0
`define WDHC_STAT_HALT_BIT  0
`define WDHC_STAT_PWDN_BIT  4
`define WDHC_STAT_TOUT_BIT  5

// ****************************************
// timing
// ****************************************
`define WDHC_SYS_PERIOD_NS  100
`define WDHC_WDT_OSC_NS     78000
`define WDHC_WDT_OSC_CYC    (`WDHC_WDT_OSC_NS / `WDHC_SYS_PERIOD_NS)
`define WDHC_BASE_DIV       256
`define WDHC_CNT_W          15
`define WDHC_INSTR_DIV      4
`define WDHC_DLY_CYC        1024
`define WDHC_IRQ_EXTRA      1

// ****************************************
// states and wake kinds
// ****************************************
`define WDHC_ST_RUN         2'h0
`define WDHC_ST_HALT        2'h1
`define WDHC_ST_WAKE        2'h2
`define WDHC_ST_HOLD        2'h3
`define WDHC_WK_RESET       2'h0
`define WDHC_WK_NEXT        2'h1
`define WDHC_WK_IRQ         2'h2

`endif

//--- verilog/wdhc_top.v
// Purpose: watchdog, halt (sleep) and reset control of an 8-bit core
// Assumes: one 10 MHz clock, all inputs synchronous, core pulses one cycle
// Notes:   fabrication options are parameters; slower clocks are enables
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "wdhc_defs.vh"

module wdhc_top #(
    parameter OPT_XTAL        = 1'b0,
    parameter OPT_WDT_EN      = 1'b1,
    parameter OPT_WDT_SRC_RC  = 1'b1,
    parameter OPT_WDT_OSC_EN  = 1'b1,
    parameter OPT_CLR_TWO     = 1'b0,
    parameter [7:0] OPT_PA_WAKE = 8'hff,
    parameter OSC_TICK_CYC    = `WDHC_WDT_OSC_CYC
) (
    input  wire                    sys_clk,
    input  wire                    rst_n,
    input  wire [`WDHC_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    input  wire                    clr_single_exec,
    input  wire                    clr_first_exec,
    input  wire                    clr_second_exec,
    input  wire                    halt_exec,
    input  wire                    external_reset_n,
    input  wire [7:0]              port_a_in,
    input  wire                    irq_request,
    input  wire                    irq_enabled,
    input  wire                    stack_full,
    output reg                     core_clk_en,
    output reg                     core_reset,
    output reg                     warm_reset,
    output reg                     resume_next,
    output reg                     irq_dispatch,
    output reg                     timeout_flag,
    output reg                     powerdown_flag,
    output reg                     halted,
    output reg                     osc_out_pin
);

    // ****************************************
    // helpers
    // ****************************************
    // last count before overflow: 256 base counts times two to the select, minus one
    function [`WDHC_CNT_W-1:0] wdhc_limit;
        input [2:0] sel;
        reg   [15:0] full;
        begin
            full = 16'd`WDHC_BASE_DIV << sel;
            wdhc_limit = full[`WDHC_CNT_W-1:0] - 15'd1;
        end
    endfunction

    localparam USE_RC = OPT_WDT_SRC_RC & OPT_WDT_OSC_EN;
    localparam [10:0] DLY_CYC = `WDHC_DLY_CYC;
    localparam [10:0] IRQ_EXTRA = `WDHC_IRQ_EXTRA;
    // cut the tick count to the divider width on purpose
    localparam integer OSC_LAST_I = OSC_TICK_CYC - 1;
    localparam [9:0] OSC_LAST = OSC_LAST_I[9:0];

    reg [1:0]              st_reg;
    reg [1:0]              st_next;
    reg [1:0]              kind_reg;
    reg [1:0]              kind_next;
    reg [10:0]             wait_reg;
    reg [10:0]             wait_next;
    reg                    dly_due_reg;
    reg                    dly_due_next;
    reg [`WDHC_CNT_W-1:0]  cnt_reg;
    reg [1:0]              idiv_reg;
    reg [9:0]              odiv_reg;
    reg [7:0]              sel_reg;
    reg [7:0]              pa_prev_reg;
    reg                    seen1_reg;
    reg                    seen2_reg;
    reg                    tout_next;
    reg                    pwdn_next;

    wire running  = (st_reg == `WDHC_ST_RUN);
    wire osc_run  = (st_reg != `WDHC_ST_HALT);
    wire inst_en  = osc_run & (idiv_reg == 2'd3);
    wire osc_tick = OPT_WDT_OSC_EN & (odiv_reg == OSC_LAST);

    // ****************************************
    // clock enables
    // ****************************************
    // instruction clock only exists while the oscillator runs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idiv_reg <= 2'd0;
        end else if (osc_run) begin
            idiv_reg <= idiv_reg + 2'd1;
        end
    end

    // free-running watchdog rc oscillator keeps going in halt
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            odiv_reg <= 10'd0;
        end else if (OPT_WDT_OSC_EN) begin
            odiv_reg <= osc_tick ? 10'd0 : odiv_reg + 10'd1;
        end
    end

    // pin shows sys/4 in rc mode and freezes while the oscillator is off
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_out_pin <= 1'b0;
        end else begin
            osc_out_pin <= OPT_XTAL ? 1'b0 : idiv_reg[1];
        end
    end

    // ****************************************
    // clear instruction decode
    // ****************************************
    wire clr1 = running & clr_first_exec;
    wire clr2 = running & clr_second_exec;
    wire pair_done = (clr1 | seen1_reg) & (clr2 | seen2_reg);
    wire clr_ok = OPT_WDT_EN & (OPT_CLR_TWO ? pair_done
                                            : running & clr_single_exec);
    wire do_halt = running & halt_exec & external_reset_n;

    // pair tracking; a repeat of the same one only re-sets its flag
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen1_reg <= 1'b0;
            seen2_reg <= 1'b0;
        end else if (clr_ok || !external_reset_n) begin
            seen1_reg <= 1'b0;
            seen2_reg <= 1'b0;
        end else begin
            seen1_reg <= seen1_reg | clr1;
            seen2_reg <= seen2_reg | clr2;
        end
    end

    // ****************************************
    // watchdog counter
    // ****************************************
    // single 15-bit count covers the 8 base stages and 7 prescale stages
    wire wdt_tick = OPT_WDT_EN & (USE_RC ? osc_tick : inst_en);
    wire hold_clr = (st_reg == `WDHC_ST_HOLD) |
                    ((st_reg == `WDHC_ST_WAKE) & (kind_reg == `WDHC_WK_RESET));
    wire wdt_clr = !external_reset_n | clr_ok | do_halt | hold_clr;
    wire wdt_ovf = wdt_tick & !wdt_clr &
                   (cnt_reg == wdhc_limit(sel_reg[`WDHC_SEL_PS_MSB:`WDHC_SEL_PS_LSB]));
    wire ovf_run  = wdt_ovf & running;
    wire ovf_halt = wdt_ovf & (st_reg == `WDHC_ST_HALT);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {`WDHC_CNT_W{1'b0}};
        end else if (wdt_clr || ovf_run) begin
            cnt_reg <= {`WDHC_CNT_W{1'b0}};
        end else if (wdt_tick) begin
            cnt_reg <= wdt_ovf ? {`WDHC_CNT_W{1'b0}} : cnt_reg + 15'd1;
        end
    end

    // ****************************************
    // select register
    // ****************************************
    // upper bits are storage only; warm reset leaves the whole byte alone
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= `WDHC_SEL_RESET;
        end else if (!external_reset_n || ovf_run) begin
            sel_reg <= `WDHC_SEL_RESET;
        end else if (reg_wr && reg_addr == `WDHC_OFS_SELECT) begin
            sel_reg <= reg_wdata;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `WDHC_OFS_SELECT) begin
            reg_rdata <= sel_reg;
        end else if (reg_addr == `WDHC_OFS_STATUS) begin
            reg_rdata <= {2'b00, timeout_flag, powerdown_flag, 3'b000, halted};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // wake sources
    // ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_prev_reg <= 8'hff;
        end else begin
            pa_prev_reg <= port_a_in;
        end
    end

    wire pa_fall = |(OPT_PA_WAKE & pa_prev_reg & ~port_a_in);
    wire irq_go  = irq_enabled & !stack_full;

    // ****************************************
    // control state machine
    // ****************************************
    always @* begin
        st_next      = st_reg;
        kind_next    = kind_reg;
        wait_next    = wait_reg;
        dly_due_next = dly_due_reg;
        case (st_reg)
            `WDHC_ST_RUN: begin
                if (!external_reset_n) begin
                    st_next = `WDHC_ST_HOLD;
                end else if (ovf_run) begin
                    st_next   = `WDHC_ST_WAKE;
                    kind_next = `WDHC_WK_RESET;
                    wait_next = 11'd0;
                end else if (do_halt) begin
                    st_next = `WDHC_ST_HALT;
                end
            end
            `WDHC_ST_HALT: begin
                wait_next = OPT_XTAL ? DLY_CYC : 11'd0;
                if (!external_reset_n) begin
                    st_next      = `WDHC_ST_HOLD;
                    dly_due_next = OPT_XTAL;
                end else if (ovf_halt) begin
                    st_next   = `WDHC_ST_WAKE;
                    kind_next = `WDHC_WK_NEXT;
                end else if (pa_fall) begin
                    st_next   = `WDHC_ST_WAKE;
                    kind_next = `WDHC_WK_NEXT;
                end else if (irq_request) begin
                    st_next   = `WDHC_ST_WAKE;
                    kind_next = irq_go ? `WDHC_WK_IRQ : `WDHC_WK_NEXT;
                    wait_next = wait_next + (irq_go ? IRQ_EXTRA : 11'd0);
                end
            end
            `WDHC_ST_WAKE: begin
                if (!external_reset_n) begin
                    st_next = `WDHC_ST_HOLD;
                end else if (wait_reg == 11'd0) begin
                    st_next = `WDHC_ST_RUN;
                end else begin
                    wait_next = wait_reg - 11'd1;
                end
            end
            default: begin
                // rc mode: pin alone sets the reset length
                if (external_reset_n) begin
                    st_next      = `WDHC_ST_WAKE;
                    kind_next    = `WDHC_WK_RESET;
                    wait_next    = dly_due_reg ? DLY_CYC : 11'd0;
                    dly_due_next = 1'b0;
                end
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= `WDHC_ST_HOLD;
            kind_reg    <= `WDHC_WK_RESET;
            wait_reg    <= 11'd0;
            dly_due_reg <= OPT_XTAL;
        end else begin
            st_reg      <= st_next;
            kind_reg    <= kind_next;
            wait_reg    <= wait_next;
            dly_due_reg <= dly_due_next;
        end
    end

    // ****************************************
    // reset-cause flags
    // ****************************************
    // set terms come last, but wdt_clr masks a time-out in any cycle that also clears
    always @* begin
        tout_next = timeout_flag;
        pwdn_next = powerdown_flag;
        if (clr_ok) begin
            tout_next = 1'b0;
            pwdn_next = 1'b0;
        end
        if (do_halt) begin
            tout_next = 1'b0;
            pwdn_next = 1'b1;
        end
        if (st_reg == `WDHC_ST_HALT && !external_reset_n) begin
            tout_next = 1'b0;
            pwdn_next = 1'b1;
        end
        if (ovf_run) begin
            tout_next = 1'b1;
        end
        if (ovf_halt) begin
            tout_next = 1'b1;
            pwdn_next = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
        end else begin
            timeout_flag   <= tout_next;
            powerdown_flag <= pwdn_next;
        end
    end

    // ****************************************
    // outputs to the core
    // ****************************************
    // core sees clock only in run; core_reset covers hold and start-up
    wire wake_done = (st_reg == `WDHC_ST_WAKE) & (wait_reg == 11'd0) &
                     external_reset_n;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk_en  <= 1'b0;
            core_reset   <= 1'b1;
            warm_reset   <= 1'b0;
            resume_next  <= 1'b0;
            irq_dispatch <= 1'b0;
            halted       <= 1'b0;
        end else begin
            core_clk_en  <= (st_next == `WDHC_ST_RUN);
            core_reset   <= (st_next == `WDHC_ST_HOLD) |
                            ((st_next == `WDHC_ST_WAKE) &
                             (kind_next == `WDHC_WK_RESET));
            warm_reset   <= ovf_halt & external_reset_n;
            resume_next  <= wake_done & (kind_reg == `WDHC_WK_NEXT);
            irq_dispatch <= wake_done & (kind_reg == `WDHC_WK_IRQ);
            halted       <= (st_next == `WDHC_ST_HALT);
        end
    end

endmodule

//--- tb/wdhc_pin_model.sv
// Purpose: reset pin and port a pins outside the block
// Assumes: port a lines have pull-ups, so a released bit reads high
// Notes:   a pin reset request is stretched to a minimum width
`timescale 1ns/1ns

module wdhc_pin_model (
    input  wire       sys_clk,
    input  wire       pin_req,
    input  wire [2:0] fall_idx,
    input  wire       fall_req,
    output reg        external_reset_n,
    output reg  [7:0] port_a_in
);
    reg [2:0] hold_cnt;

    initial begin
        external_reset_n = 1'b1;
        port_a_in = 8'hff;
        hold_cnt = 3'h0;
    end

    // a short request still holds the pin low for five clocks
    always @(posedge sys_clk) begin
        hold_cnt <= pin_req ? 3'h4 : (hold_cnt != 3'h0 ? hold_cnt - 3'h1 : 3'h0);
        external_reset_n <= !pin_req && (hold_cnt == 3'h0);
        port_a_in <= fall_req ? ~(8'h01 << fall_idx) : 8'hff; // pull-up when released
    end
endmodule

//--- tb/wdhc_top_monitor.sv
// Purpose: port checks for the watchdog, halt and reset block
// Assumes: rc oscillator option, single clear instruction scheme
// Notes:   bound into every wdhc_top instance
`timescale 1ns/1ns
`include "wdhc_defs.vh"

module wdhc_monitor (
    input wire                    sys_clk,
    input wire                    rst_n,
    input wire [`WDHC_ADDR_W-1:0] reg_addr,
    input wire                    reg_rd,
    input wire [7:0]              reg_rdata,
    input wire                    clr_single_exec,
    input wire                    halt_exec,
    input wire                    external_reset_n,
    input wire                    core_clk_en,
    input wire                    core_reset,
    input wire                    warm_reset,
    input wire                    resume_next,
    input wire                    irq_dispatch,
    input wire                    timeout_flag,
    input wire                    powerdown_flag,
    input wire                    halted
);
    // one clock domain, quiet while power-up reset is held
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    halt_entry_a: assert property (
        halt_exec && core_clk_en && external_reset_n |=>
        halted && !core_clk_en && powerdown_flag && !timeout_flag)
        else $error("halt entry wrong");
    clear_flags_a: assert property (
        clr_single_exec && core_clk_en && external_reset_n && !halt_exec |=>
        !powerdown_flag && !timeout_flag)
        else $error("clear left a flag set");
    pin_reset_a: assert property (
        !external_reset_n |=> core_reset)
        else $error("pin low without chip reset");
    rc_release_a: assert property (
        $rose(external_reset_n) |-> ##[1:3] (core_clk_en && !core_reset))
        else $error("rc release not prompt");
    warm_kind_a: assert property (
        warm_reset |-> ($past(halted) || $past(halted, 2)) && !core_reset
        && timeout_flag && powerdown_flag)
        else $error("warm reset out of place");
    resume_time_a: assert property (
        resume_next |-> core_clk_en && $past(halted, 2) && !$past(halted))
        else $error("resume timing wrong");
    irq_delay_a: assert property (
        irq_dispatch |-> core_clk_en && $past(halted, 3) && !$past(halted, 2))
        else $error("interrupt start not delayed");
    status_read_a: assert property (
        reg_rd && reg_addr == `WDHC_OFS_STATUS |=> reg_rdata ==
        {2'b00, $past(timeout_flag), $past(powerdown_flag), 3'b000, $past(halted)})
        else $error("status read wrong");
endmodule

bind wdhc_top wdhc_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clr_single_exec(clr_single_exec),
    .halt_exec(halt_exec), .external_reset_n(external_reset_n), .core_clk_en(core_clk_en),
    .core_reset(core_reset), .warm_reset(warm_reset), .resume_next(resume_next),
    .irq_dispatch(irq_dispatch), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .halted(halted));

//--- tb/wdhc_top_bench.sv
// Purpose: self-checking bench for the watchdog, halt and reset block
// Assumes: rc option, watchdog on its own oscillator, single clear in DUT, pair clear in DUT_PAIR
// Notes:   tick shortened to 4 clocks, so select 0 overflows after 1024
`timescale 1ns/1ns
`include "wdhc_defs.vh"

module wdhc_top_bench;
    reg                    sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg                    clr_single_exec = 1'b0, halt_exec = 1'b0, irq_request = 1'b0;
    reg                    irq_enabled = 1'b0, stack_full = 1'b0, pin_req = 1'b0;
    reg                    fall_req = 1'b0;
    reg                    clr_first_exec = 1'b0, clr_second_exec = 1'b0;
    reg [2:0]              fall_idx = 3'h5;
    reg [`WDHC_ADDR_W-1:0] reg_addr = 4'h0;
    reg [7:0]              reg_wdata = 8'h00;
    wire [7:0]             reg_rdata, port_a_in;
    wire                   external_reset_n, core_clk_en, core_reset, warm_reset;
    wire                   resume_next, irq_dispatch, timeout_flag, powerdown_flag, halted;
    wire                   osc_out_pin, pair_timeout, pair_powerdown;
    integer                fail_count = 0, num_checks = 0;

    // pair-clear inputs stay low: this build uses the single clear
    wdhc_top #(.OSC_TICK_CYC(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .clr_single_exec(clr_single_exec), .clr_first_exec(1'b0),
        .clr_second_exec(1'b0), .halt_exec(halt_exec), .external_reset_n(external_reset_n),
        .port_a_in(port_a_in), .irq_request(irq_request), .irq_enabled(irq_enabled),
        .stack_full(stack_full), .core_clk_en(core_clk_en), .core_reset(core_reset),
        .warm_reset(warm_reset), .resume_next(resume_next), .irq_dispatch(irq_dispatch),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .halted(halted),
        .osc_out_pin(osc_out_pin));
    // second build with the pair-clear option; its single clear is tied off
    wdhc_top #(.OSC_TICK_CYC(4), .OPT_CLR_TWO(1'b1)) DUT_PAIR (.sys_clk(sys_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(), .clr_single_exec(1'b0),
        .clr_first_exec(clr_first_exec), .clr_second_exec(clr_second_exec),
        .halt_exec(halt_exec), .external_reset_n(external_reset_n), .port_a_in(port_a_in),
        .irq_request(irq_request), .irq_enabled(irq_enabled), .stack_full(stack_full),
        .core_clk_en(), .core_reset(), .warm_reset(), .resume_next(), .irq_dispatch(),
        .timeout_flag(pair_timeout), .powerdown_flag(pair_powerdown), .halted(),
        .osc_out_pin());
    wdhc_pin_model pins (.sys_clk(sys_clk), .pin_req(pin_req), .fall_idx(fall_idx),
        .fall_req(fall_req), .external_reset_n(external_reset_n), .port_a_in(port_a_in));

    always #50 sys_clk = ~sys_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // flags packed as {timeout, powerdown}, the order software reads them
    task automatic flags(input logic [1:0] exp);
        check("flags", {6'h0, timeout_flag, powerdown_flag}, {6'h0, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("rdata", reg_rdata, exp);
    endtask
    // one-cycle pulse: 0 halt, 1 clear, 2 pin reset, 3 port a fall, 4/5 pair halves
    task automatic poke(input int s);
        @(posedge sys_clk);
        halt_exec <= (s == 0);
        clr_single_exec <= (s == 1);
        pin_req <= (s == 2);
        fall_req <= (s == 3);
        clr_first_exec <= (s == 4);
        clr_second_exec <= (s == 5);
        @(posedge sys_clk);
        {halt_exec, clr_single_exec, pin_req, fall_req, clr_first_exec, clr_second_exec} <= 6'h00;
        #1;
    endtask
    function automatic logic pick(input int s);
        pick = s == 0 ? core_clk_en : s == 1 ? timeout_flag : s == 2 ? resume_next :
               s == 3 ? irq_dispatch : s == 4 ? warm_reset : core_reset;
    endfunction
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_on(input int s, input int lim);
        int i;
        i = 0;
        while (pick(s) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            i++;
            if (i > lim) begin
                fail_count++;
                $display("CHECK FAILED wait %0d expected 1 seen 0", s);
                wrap_up;
            end
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_power;
        flags(2'b00);
        wait_on(0, 8);
        check("core_reset", {7'h0, core_reset}, 8'h00);
        rd(`WDHC_OFS_SELECT, `WDHC_SEL_RESET);
    endtask
    // divided output inverts every two clocks, so a period of four
    task automatic t_osc;
        logic first;
        first = osc_out_pin;
        repeat (2) @(posedge sys_clk);
        #1;
        check("osc_half", {7'h0, osc_out_pin}, {7'h0, ~first});
        repeat (2) @(posedge sys_clk);
        #1;
        check("osc_full", {7'h0, osc_out_pin}, {7'h0, first});
    endtask
    task automatic t_regs;
        wr(`WDHC_OFS_SELECT, 8'ha8);
        rd(`WDHC_OFS_SELECT, 8'ha8);
        wr(`WDHC_OFS_STATUS, 8'hff);
        rd(`WDHC_OFS_STATUS, 8'h00);
        rd(4'h5, 8'h00);
    endtask
    // bit 3 set must not lengthen the 1:2 prescale
    task automatic t_run_timeout;
        wr(`WDHC_OFS_SELECT, 8'h09);
        poke(1);
        repeat (1900) @(posedge sys_clk);
        #1;
        flags(2'b00);
        wait_on(1, 300);
        flags(2'b10);
        wait_on(0, 20);
        rd(`WDHC_OFS_SELECT, `WDHC_SEL_RESET);
    endtask
    task automatic t_pin_run;
        poke(2);
        wait_on(5, 4);
        flags(2'b10);
        wait_on(0, 20);
    endtask
    // pair build: the single clear and a repeated half leave it armed
    task automatic t_pair;
        check("pair_to", {7'h0, pair_timeout}, 8'h01);
        poke(1);
        check("pair_to", {7'h0, pair_timeout}, 8'h01);
        poke(4);
        poke(4);
        check("pair_to", {7'h0, pair_timeout}, 8'h01);
        poke(5);
        check("pair_to", {7'h0, pair_timeout}, 8'h00);
    endtask
    task automatic t_halt_port;
        logic frozen;
        wr(`WDHC_OFS_SELECT, 8'h00);
        poke(0);
        check("clk_en", {7'h0, core_clk_en}, 8'h00);
        flags(2'b01);
        // one edge for the last launched value, then the pin must hold
        @(posedge sys_clk);
        #1;
        frozen = osc_out_pin;
        repeat (2) @(posedge sys_clk);
        #1;
        check("osc_frozen", {7'h0, osc_out_pin}, {7'h0, frozen});
        poke(3);
        wait_on(2, 6);
        check("halted", {7'h0, halted}, 8'h00);
    endtask
    task automatic t_irq_wake(input logic full, input int s);
        irq_enabled <= 1'b1;
        stack_full <= full;
        poke(0);
        irq_request <= 1'b1;
        wait_on(s, 8);
        @(posedge sys_clk);
        irq_request <= 1'b0;
    endtask
    task automatic t_wdt_wake;
        poke(0);
        wait_on(4, 1100);
        flags(2'b11);
        wait_on(0, 10);
        poke(1);
        flags(2'b00);
    endtask
    task automatic t_pin_halt;
        poke(0);
        poke(2);
        wait_on(5, 4);
        flags(2'b01);
        wait_on(0, 20);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        t_power;
        t_osc;
        t_regs;
        t_run_timeout;
        t_pin_run;
        t_pair;
        t_halt_port;
        t_irq_wake(1'b1, 2);
        t_irq_wake(1'b0, 3);
        t_wdt_wake;
        t_pin_halt;
        wrap_up;
    end
endmodule
